// ===== common/scb_pkg.sv
package scb_pkg;

  // ----------------------------------------------------------------
  // register placement and reset image
  // ----------------------------------------------------------------
  localparam logic [7:0]  SYSCTL_OFFSET   = 8'h80;
  localparam logic [31:0] SYSCTL_RESET    = 32'h08009060;
  // only bits 21 down to 5 live in this block; the rest read as zero here
  localparam logic [31:0] SYSCTL_SPAN     = 32'h003FFFE0;
  localparam int          NUM_SOCKETS     = 2;
  localparam int          FUNC_W          = 3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SUPPLY_PROT  = 21;
  localparam int BIT_RED_VIDEO    = 20;
  localparam int BIT_RSVD_HI_MSB  = 19;
  localparam int BIT_RSVD_HI_LSB  = 16;
  localparam int BIT_BURST_DN     = 15;
  localparam int BIT_BURST_UP     = 14;
  localparam int BIT_ACTIVITY     = 13;
  localparam int BIT_RSVD_ONE     = 12;
  localparam int BIT_STREAM_BUSY  = 11;
  localparam int BIT_UP_DELAY     = 10;
  localparam int BIT_DOWN_DELAY   = 9;
  localparam int BIT_PROBE        = 8;
  localparam int BIT_RSVD_ZERO    = 7;
  localparam int BIT_LOW_POWER    = 6;
  localparam int BIT_ID_LOCK      = 5;

  // byte lanes carrying the writable fields
  localparam int LANE_SOCKET      = 2;
  localparam int LANE_BURST       = 1;
  localparam int LANE_GLOBAL      = 0;

  // ----------------------------------------------------------------
  // reset values of the fields
  // ----------------------------------------------------------------
  localparam logic RST_SUPPLY_PROT = SYSCTL_RESET[BIT_SUPPLY_PROT];
  localparam logic RST_RED_VIDEO   = SYSCTL_RESET[BIT_RED_VIDEO];
  localparam logic RST_BURST_DN    = SYSCTL_RESET[BIT_BURST_DN];
  localparam logic RST_BURST_UP    = SYSCTL_RESET[BIT_BURST_UP];
  localparam logic RST_RSVD_ONE    = SYSCTL_RESET[BIT_RSVD_ONE];
  localparam logic RST_RSVD_ZERO   = SYSCTL_RESET[BIT_RSVD_ZERO];
  localparam logic RST_LOW_POWER   = SYSCTL_RESET[BIT_LOW_POWER];
  localparam logic RST_ID_LOCK     = SYSCTL_RESET[BIT_ID_LOCK];

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 8;
  localparam int PWR_UP_DELAY_NS    = 100000;
  localparam int PWR_DOWN_DELAY_NS  = 100000;
  localparam int SER_BIT_NS         = 1000;
  localparam int PWR_UP_DELAY_CYC   = (PWR_UP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWR_DOWN_DELAY_CYC = (PWR_DOWN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SER_BIT_CYC        = (SER_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWR_STREAM_BITS    = 8;
  localparam int SYNC_STAGES        = 2;

  // ----------------------------------------------------------------
  // power switch sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SCB_SEQ_IDLE  = 3'b001,
    SCB_SEQ_SHIFT = 3'b010,
    SCB_SEQ_DELAY = 3'b100
  } scb_seq_state_t;

endpackage

// ===== rtl/scb_sync.sv
`timescale 1ns/100ps
module scb_sync
  import scb_pkg::*;
#(
  parameter int           WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ===== rtl/scb_pwr_seq.sv
`timescale 1ns/100ps
module scb_pwr_seq
  import scb_pkg::*;
#(
  parameter int UP_DELAY_CYCLES   = PWR_UP_DELAY_CYC,
  parameter int DOWN_DELAY_CYCLES = PWR_DOWN_DELAY_CYC,
  parameter int BIT_CYCLES        = SER_BIT_CYC,
  parameter int STREAM_BITS       = PWR_STREAM_BITS
)
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   ctx_clear,
  // power change request
  input  wire logic                   req,
  input  wire logic                   req_up,
  input  wire logic [STREAM_BITS-1:0] req_word,
  // serial stream to the power switch
  output logic                        ser_clk,
  output logic                        ser_data,
  output logic                        ser_latch,
  // progress flags
  output logic                        stream_busy,
  output logic                        up_busy,
  output logic                        down_busy
);

  localparam int DLY_MAX = (UP_DELAY_CYCLES > DOWN_DELAY_CYCLES) ? UP_DELAY_CYCLES : DOWN_DELAY_CYCLES;
  localparam int DLY_W   = $clog2(DLY_MAX + 1);
  localparam int TICK_W  = $clog2(BIT_CYCLES + 1);
  localparam int BIT_W   = $clog2(STREAM_BITS + 1);
  localparam logic [DLY_W-1:0]  UP_LOAD   = DLY_W'(UP_DELAY_CYCLES - 1);
  localparam logic [DLY_W-1:0]  DOWN_LOAD = DLY_W'(DOWN_DELAY_CYCLES - 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(BIT_CYCLES - 1);
  localparam logic [TICK_W-1:0] TICK_HALF = TICK_W'(BIT_CYCLES / 2);
  localparam logic [BIT_W-1:0]  BIT_LAST  = BIT_W'(STREAM_BITS - 1);

  scb_seq_state_t         state;
  logic [STREAM_BITS-1:0] shreg;
  logic [TICK_W-1:0]      tick;
  logic [BIT_W-1:0]       bit_cnt;
  logic [DLY_W-1:0]       dly_cnt;
  logic                   dir_up;
  logic                   start;
  logic                   shift_done;
  logic                   delay_done;

  // requests arriving while busy are dropped; the caller sees stream_busy
  assign start      = (state == SCB_SEQ_IDLE) && req;
  assign shift_done = (state == SCB_SEQ_SHIFT) && (tick == TICK_LAST) && (bit_cnt == BIT_LAST);
  assign delay_done = (state == SCB_SEQ_DELAY) && (dly_cnt == '0);

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state   <= SCB_SEQ_IDLE;
      shreg   <= '0;
      tick    <= '0;
      bit_cnt <= '0;
      dly_cnt <= '0;
      dir_up  <= 1'b0;
    end
    else
    begin
      unique case (state)
        SCB_SEQ_IDLE:
        begin
          if (req)
          begin
            state   <= SCB_SEQ_SHIFT;
            shreg   <= req_word;
            dir_up  <= req_up;
            tick    <= '0;
            bit_cnt <= '0;
          end
        end
        SCB_SEQ_SHIFT:
        begin
          if (tick == TICK_LAST)
          begin
            tick    <= '0;
            shreg   <= {shreg[STREAM_BITS-2:0], 1'b0};
            bit_cnt <= bit_cnt + 1'b1;
            if (bit_cnt == BIT_LAST)
            begin
              state   <= SCB_SEQ_DELAY;
              dly_cnt <= dir_up ? UP_LOAD : DOWN_LOAD;
            end
          end
          else
          begin
            tick <= tick + 1'b1;
          end
        end
        SCB_SEQ_DELAY:
        begin
          if (dly_cnt == '0)
            state <= SCB_SEQ_IDLE;
          else
            dly_cnt <= dly_cnt - 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial pins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ser_clk   <= 1'b0;
      ser_data  <= 1'b0;
      ser_latch <= 1'b0;
    end
    else
    begin
      ser_clk   <= (state == SCB_SEQ_SHIFT) && (tick >= TICK_HALF);
      ser_data  <= (state == SCB_SEQ_SHIFT) && shreg[STREAM_BITS-1];
      ser_latch <= shift_done;
    end
  end

  // ----------------------------------------------------------------
  // progress flags
  // ----------------------------------------------------------------
  // stream busy span
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      stream_busy <= 1'b0;
    else if (start)
      stream_busy <= 1'b1;
    else if (delay_done)
      stream_busy <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      up_busy <= 1'b0;
    else if (shift_done && dir_up)
      up_busy <= 1'b1;
    else if (delay_done || ctx_clear)
      up_busy <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      down_busy <= 1'b0;
    else if (shift_done && !dir_up)
      down_busy <= 1'b1;
    else if (delay_done || ctx_clear)
      down_busy <= 1'b0;
  end

endmodule

// ===== rtl/scb_sysctl.sv
`timescale 1ns/100ps
// Overview of operation
// - per-socket bit 21 disables supply protection
// - bit 20 floats card lines AD25-AD22
// - bits 19 to 16 read zero
// - bit 15 allows downstream read bursts
// - bit 14 allows upstream read bursts
// - bit 13 activity, cleared by a read with byte lane 1 enabled
// - bit 12 reads one, bit 7 zero
// - bit 11 busy during stream and delay
// - bit 10 set after power-up stream
// - bit 9 set after power-down stream
// - bit 8 set during card interrogation
// - bit 6 shared low power enable
// - bit 5 locks identification registers
// - global-only bits survive bus reset
// - bits 10-8 cleared by bus reset unless PME
// - socket bits kept per function
// - word at 0x80, functions 0 and 1
module scb_sysctl
  import scb_pkg::*;
#(
  parameter int UP_DELAY_CYCLES   = PWR_UP_DELAY_CYC,
  parameter int DOWN_DELAY_CYCLES = PWR_DOWN_DELAY_CYC,
  parameter int BIT_CYCLES        = SER_BIT_CYC,
  parameter int STREAM_BITS       = PWR_STREAM_BITS
)
(
  // clock and global reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // bus reset pin and power management state
  input  wire logic                   bus_reset_n,
  input  wire logic                   pme_en,
  // configuration access
  input  wire logic                   cfg_rd,
  input  wire logic                   cfg_wr,
  input  wire logic [FUNC_W-1:0]      cfg_func,
  input  wire logic [7:0]             cfg_addr,
  input  wire logic [3:0]             cfg_be,
  input  wire logic [31:0]            cfg_wdata,
  output logic      [31:0]            cfg_rdata,
  output logic                        cfg_ack,
  output logic                        cfg_hit,
  // socket events
  input  wire logic [NUM_SOCKETS-1:0] card_access,
  input  wire logic [NUM_SOCKETS-1:0] probe_start,
  input  wire logic [NUM_SOCKETS-1:0] probe_done,
  // power change requests
  input  wire logic [NUM_SOCKETS-1:0] pwr_req,
  input  wire logic [NUM_SOCKETS-1:0] pwr_req_up,
  input  wire logic [STREAM_BITS-1:0] pwr_req_word0,
  input  wire logic [STREAM_BITS-1:0] pwr_req_word1,
  // power switch serial stream
  output logic      [NUM_SOCKETS-1:0] pwr_ser_clk,
  output logic      [NUM_SOCKETS-1:0] pwr_ser_data,
  output logic      [NUM_SOCKETS-1:0] pwr_ser_latch,
  // per-socket controls
  output logic      [NUM_SOCKETS-1:0] supply_protect_disable,
  output logic      [NUM_SOCKETS-1:0] reduced_video_port_en,
  output logic      [NUM_SOCKETS-1:0] socket_activity_flag,
  output logic      [NUM_SOCKETS-1:0] card_probe_busy,
  output logic      [NUM_SOCKETS-1:0] power_stream_busy,
  output logic      [NUM_SOCKETS-1:0] power_up_delay_busy,
  output logic      [NUM_SOCKETS-1:0] power_down_delay_busy,
  // shared controls
  output logic                        read_burst_down_en,
  output logic                        read_burst_up_en,
  output logic                        low_power_en,
  output logic                        id_regs_lock
);

  // ----------------------------------------------------------------
  // field composition
  // ----------------------------------------------------------------
  function automatic logic [31:0] compose_word(
    input logic prot_dis,
    input logic red_vid,
    input logic burst_dn,
    input logic burst_up,
    input logic activity,
    input logic stream,
    input logic up_dly,
    input logic down_dly,
    input logic probe,
    input logic low_pwr,
    input logic id_lock
  );
    logic [31:0] w;
    w                                   = '0;
    w[BIT_SUPPLY_PROT]                  = prot_dis;
    w[BIT_RED_VIDEO]                    = red_vid;
    w[BIT_RSVD_HI_MSB:BIT_RSVD_HI_LSB]  = '0;
    w[BIT_BURST_DN]                     = burst_dn;
    w[BIT_BURST_UP]                     = burst_up;
    w[BIT_ACTIVITY]                     = activity;
    w[BIT_RSVD_ONE]                     = RST_RSVD_ONE;
    w[BIT_RSVD_ZERO]                    = RST_RSVD_ZERO;
    w[BIT_STREAM_BUSY]                  = stream;
    w[BIT_UP_DELAY]                     = up_dly;
    w[BIT_DOWN_DELAY]                   = down_dly;
    w[BIT_PROBE]                        = probe;
    w[BIT_LOW_POWER]                    = low_pwr;
    w[BIT_ID_LOCK]                      = id_lock;
    return w & SYSCTL_SPAN;
  endfunction

  // ----------------------------------------------------------------
  // bus reset and access decode
  // ----------------------------------------------------------------
  logic                   bus_reset_n_s;
  logic                   ctx_clear;
  logic                   hit;
  logic                   sock;
  logic                   wr_hit;
  logic                   glob_wr;
  logic                   rd_clear;
  logic [31:0]            sock_word [NUM_SOCKETS];

  scb_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_bus_reset_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (bus_reset_n),
    .sync_out (bus_reset_n_s)
  );

  assign ctx_clear = !bus_reset_n_s && !pme_en;

  assign hit     = (cfg_addr[7:2] == SYSCTL_OFFSET[7:2]) && (cfg_func < FUNC_W'(NUM_SOCKETS));
  assign sock    = cfg_func[0];
  assign wr_hit  = cfg_wr && hit;
  assign glob_wr = wr_hit && (cfg_func == '0);
  assign rd_clear = cfg_rd && hit && cfg_be[LANE_BURST];

  // ----------------------------------------------------------------
  // shared fields
  // ----------------------------------------------------------------
  // loaded with their reset values by global reset only
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      read_burst_down_en <= RST_BURST_DN;
      read_burst_up_en   <= RST_BURST_UP;
    end
    else if (glob_wr && cfg_be[LANE_BURST])
    begin
      read_burst_down_en <= cfg_wdata[BIT_BURST_DN];
      read_burst_up_en   <= cfg_wdata[BIT_BURST_UP];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      low_power_en <= RST_LOW_POWER;
      id_regs_lock <= RST_ID_LOCK;
    end
    else if (glob_wr && cfg_be[LANE_GLOBAL])
    begin
      low_power_en <= cfg_wdata[BIT_LOW_POWER];
      id_regs_lock <= cfg_wdata[BIT_ID_LOCK];
    end
  end

  // ----------------------------------------------------------------
  // per-socket fields
  // ----------------------------------------------------------------
  for (genvar s = 0; s < NUM_SOCKETS; s++)
  begin : g_sock
    logic this_sock;
    assign this_sock = (sock == 1'(s));

    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
      begin
        supply_protect_disable[s] <= RST_SUPPLY_PROT;
        reduced_video_port_en[s]  <= RST_RED_VIDEO;
      end
      else if (wr_hit && this_sock && cfg_be[LANE_SOCKET])
      begin
        supply_protect_disable[s] <= cfg_wdata[BIT_SUPPLY_PROT];
        reduced_video_port_en[s]  <= cfg_wdata[BIT_RED_VIDEO];
      end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        socket_activity_flag[s] <= 1'b0;
      else if (card_access[s])
        socket_activity_flag[s] <= 1'b1;
      else if (rd_clear && this_sock)
        socket_activity_flag[s] <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        card_probe_busy[s] <= 1'b0;
      else if (probe_start[s])
        card_probe_busy[s] <= 1'b1;
      else if (probe_done[s] || ctx_clear)
        card_probe_busy[s] <= 1'b0;
    end

    scb_pwr_seq #(
      .UP_DELAY_CYCLES   (UP_DELAY_CYCLES),
      .DOWN_DELAY_CYCLES (DOWN_DELAY_CYCLES),
      .BIT_CYCLES        (BIT_CYCLES),
      .STREAM_BITS       (STREAM_BITS)
    ) u_pwr_seq (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .ctx_clear   (ctx_clear),
      .req         (pwr_req[s]),
      .req_up      (pwr_req_up[s]),
      .req_word    ((s == 0) ? pwr_req_word0 : pwr_req_word1),
      .ser_clk     (pwr_ser_clk[s]),
      .ser_data    (pwr_ser_data[s]),
      .ser_latch   (pwr_ser_latch[s]),
      .stream_busy (power_stream_busy[s]),
      .up_busy     (power_up_delay_busy[s]),
      .down_busy   (power_down_delay_busy[s])
    );

    assign sock_word[s] = compose_word(
      supply_protect_disable[s],
      reduced_video_port_en[s],
      read_burst_down_en,
      read_burst_up_en,
      socket_activity_flag[s],
      power_stream_busy[s],
      power_up_delay_busy[s],
      power_down_delay_busy[s],
      card_probe_busy[s],
      low_power_en,
      id_regs_lock
    );
  end

  // ----------------------------------------------------------------
  // read return
  // ----------------------------------------------------------------
  // status bits have no write path
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_rdata <= '0;
      cfg_ack   <= 1'b0;
      cfg_hit   <= 1'b0;
    end
    else
    begin
      // unmapped offsets still acknowledge so the requester never hangs
      cfg_ack   <= cfg_rd || cfg_wr;
      cfg_hit   <= (cfg_rd || cfg_wr) && hit;
      cfg_rdata <= (cfg_rd && hit) ? sock_word[sock] : '0;
    end
  end

endmodule

// ===== bench/scb_sysctl_asserts.sv
`timescale 1ns/100ps
module scb_sysctl_asserts
  import scb_pkg::*;
(
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // configuration access
  input wire logic                   cfg_rd,
  input wire logic                   cfg_wr,
  input wire logic [FUNC_W-1:0]      cfg_func,
  input wire logic [7:0]             cfg_addr,
  input wire logic [3:0]             cfg_be,
  input wire logic [31:0]            cfg_wdata,
  input wire logic [31:0]            cfg_rdata,
  input wire logic                   cfg_ack,
  // socket side
  input wire logic [NUM_SOCKETS-1:0] card_access,
  input wire logic [NUM_SOCKETS-1:0] probe_start,
  input wire logic [NUM_SOCKETS-1:0] pwr_req,
  input wire logic [NUM_SOCKETS-1:0] supply_protect_disable,
  input wire logic [NUM_SOCKETS-1:0] reduced_video_port_en,
  input wire logic [NUM_SOCKETS-1:0] socket_activity_flag,
  input wire logic [NUM_SOCKETS-1:0] card_probe_busy,
  input wire logic [NUM_SOCKETS-1:0] power_stream_busy,
  input wire logic [NUM_SOCKETS-1:0] power_up_delay_busy,
  // shared controls
  input wire logic                   read_burst_down_en,
  input wire logic                   read_burst_up_en,
  input wire logic                   low_power_en,
  input wire logic                   id_regs_lock
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic hit;
  assign hit = (cfg_addr[7:2] == 6'h20) && (cfg_func < 3'h2);
  sequence s_up_start;
    $rose(power_up_delay_busy[0]);
  endsequence
  sequence s_up_hold;
    (power_up_delay_busy[0] && power_stream_busy[0]) [*8];
  endsequence
  property p_ack;
    cfg_rd || cfg_wr |=> cfg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge");
  property p_fixed;
    cfg_rd && hit |=> cfg_rdata[12] && !cfg_rdata[7] && (cfg_rdata[19:16] == 4'h0);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
  property p_act_clr;
    cfg_rd && hit && cfg_func == 3'h0 && cfg_be[1] && !card_access[0] |=> !socket_activity_flag[0];
  endproperty
  a_act_clr: assert property (p_act_clr) else $error("activity not cleared");
  property p_act_set;
    card_access[1] |=> socket_activity_flag[1];
  endproperty
  a_act_set: assert property (p_act_set) else $error("activity not set");
  property p_probe;
    probe_start[0] |=> card_probe_busy[0];
  endproperty
  a_probe: assert property (p_probe) else $error("probe flag not set");
  property p_stream;
    pwr_req[0] && !power_stream_busy[0] |=> power_stream_busy[0];
  endproperty
  a_stream: assert property (p_stream) else $error("stream flag not set");
  property p_up_delay;
    s_up_start |-> s_up_hold;
  endproperty
  a_up_delay: assert property (p_up_delay) else $error("power-up delay cut short");
  property p_f1_global;
    cfg_wr && cfg_func == 3'h1 |=> $stable({read_burst_down_en, read_burst_up_en, low_power_en, id_regs_lock});
  endproperty
  a_f1_global: assert property (p_f1_global) else $error("function 1 changed shared bits");
  property p_burst_wr;
    cfg_wr && hit && cfg_func == 3'h0 && cfg_be[1] |=>
      read_burst_down_en == $past(cfg_wdata[15]) && read_burst_up_en == $past(cfg_wdata[14]);
  endproperty
  a_burst_wr: assert property (p_burst_wr) else $error("burst enables not written");
  property p_sock_wr;
    cfg_wr && hit && cfg_func == 3'h1 && cfg_be[2] |=>
      supply_protect_disable[1] == $past(cfg_wdata[21]) && reduced_video_port_en[1] == $past(cfg_wdata[20]);
  endproperty
  a_sock_wr: assert property (p_sock_wr) else $error("socket bits not written");
endmodule
bind scb_sysctl scb_sysctl_asserts u_chk (.ref_clk, .rst, .cfg_rd, .cfg_wr, .cfg_func, .cfg_addr, .cfg_be,
  .cfg_wdata, .cfg_rdata, .cfg_ack, .card_access, .probe_start, .pwr_req, .supply_protect_disable,
  .reduced_video_port_en, .socket_activity_flag, .card_probe_busy, .power_stream_busy, .power_up_delay_busy,
  .read_burst_down_en, .read_burst_up_en, .low_power_en, .id_regs_lock);

// ===== bench/testbench.sv
`timescale 1ns/100ps
module testbench
  import scb_pkg::*;
;
  logic       ref_clk = 0, rst = 1, bus_reset_n = 1, pme_en = 1, cfg_rd = 0, cfg_wr = 0, cfg_ack, cfg_hit;
  logic [2:0] cfg_func = 0;
  logic [7:0] cfg_addr = 0, pwr_req_word0 = 0, pwr_req_word1 = 0, got;
  logic [3:0] cfg_be = 0;
  logic [31:0] cfg_wdata = 0, cfg_rdata;
  logic [1:0] card_access = 0, probe_start = 0, probe_done = 0, pwr_req = 0, pwr_req_up = 0;
  logic [1:0] pwr_ser_clk, pwr_ser_data, pwr_ser_latch, supply_protect_disable, reduced_video_port_en;
  logic [1:0] socket_activity_flag, card_probe_busy, power_stream_busy, power_up_delay_busy, power_down_delay_busy;
  logic       read_burst_down_en, read_burst_up_en, low_power_en, id_regs_lock;
  int         n_fail = 0, n_tests = 0;

  always #4 ref_clk = ~ref_clk;

  // short delays keep the run brief
  scb_sysctl #(.UP_DELAY_CYCLES(20), .DOWN_DELAY_CYCLES(20), .BIT_CYCLES(4), .STREAM_BITS(8)) u_dut
  (.ref_clk, .rst, .bus_reset_n, .pme_en, .cfg_rd, .cfg_wr, .cfg_func, .cfg_addr, .cfg_be, .cfg_wdata,
   .cfg_rdata, .cfg_ack, .cfg_hit, .card_access, .probe_start, .probe_done, .pwr_req, .pwr_req_up,
   .pwr_req_word0, .pwr_req_word1, .pwr_ser_clk, .pwr_ser_data, .pwr_ser_latch, .supply_protect_disable,
   .reduced_video_port_en, .socket_activity_flag, .card_probe_busy, .power_stream_busy, .power_up_delay_busy,
   .power_down_delay_busy, .read_burst_down_en, .read_burst_up_en, .low_power_en, .id_regs_lock);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask

  // result stands one cycle, so it is sampled just after the taking edge
  task automatic acc(input logic wr, input logic [2:0] f, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(posedge ref_clk);
    cfg_rd <= !wr;
    cfg_wr <= wr;
    cfg_func <= f;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_rd <= 0;
    cfg_wr <= 0;
    #1;
    chk("ack", cfg_ack, 1);
  endtask

  task automatic rchk(input logic [2:0] f, input logic [31:0] exp);
    acc(0, f, 8'h80, 4'hF, 0);
    chk("hit", cfg_hit, 1);
    chk("rdata", cfg_rdata, exp);
  endtask

  task automatic globals(input logic [3:0] exp);
    chk("globals", {read_burst_down_en, read_burst_up_en, low_power_en, id_regs_lock}, exp);
  endtask

  task automatic bus_reset();
    @(posedge ref_clk);
    bus_reset_n <= 0;
    repeat (4) @(posedge ref_clk);
    bus_reset_n <= 1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(0, SYSCTL_RESET & SYSCTL_SPAN);
    globals(4'hB);
    acc(0, 3'h2, 8'h80, 4'hF, 0);
    chk("unmapped func", cfg_hit, 0);
    chk("unmapped rdata", cfg_rdata, 0);
    acc(0, 3'h0, 8'h84, 4'hF, 0);
    chk("unmapped addr", cfg_hit, 0);
  endtask

  task automatic t_write();
    acc(1, 0, 8'h80, 4'hF, 32'hFFFFFFFF);
    rchk(0, 32'h0030D060);
    chk("socket0 ctl", {supply_protect_disable[0], reduced_video_port_en[0]}, 2'h3);
    acc(1, 1, 8'h80, 4'hF, 0);
    globals(4'hF);
    rchk(1, 32'h0000D060);
    chk("prot per socket", supply_protect_disable, 2'h1);
    acc(1, 0, 8'h80, 4'h2, 0);
    globals(4'h3);
    acc(1, 0, 8'h80, 4'hF, 0);
    rchk(0, 32'h00001000);
  endtask

  task automatic t_activity();
    @(posedge ref_clk);
    card_access <= 2'h3;
    @(posedge ref_clk);
    card_access <= 0;
    rchk(1, 32'h00003000);
    rchk(1, 32'h00001000);
    chk("activity socket0", socket_activity_flag, 2'h1);
    rchk(0, 32'h00003000);
  endtask

  task automatic t_probe();
    @(posedge ref_clk);
    probe_start <= 2'h1;
    @(posedge ref_clk);
    probe_start <= 0;
    rchk(0, 32'h00001100);
    bus_reset();
    chk("probe kept", card_probe_busy, 2'h1);
    chk("burst kept", read_burst_down_en, 0);
    @(posedge ref_clk);
    pme_en <= 0;
    bus_reset();
    chk("probe cleared", card_probe_busy, 0);
    @(posedge ref_clk);
    probe_start <= 2'h1;
    @(posedge ref_clk);
    probe_start <= 0;
    probe_done <= 2'h1;
    @(posedge ref_clk);
    probe_done <= 0;
    @(posedge ref_clk);
    #1;
    chk("probe done", card_probe_busy, 0);
  endtask

  task automatic t_power(input logic up);
    @(posedge ref_clk);
    pwr_req <= 2'h1;
    pwr_req_up <= {1'b0, up};
    pwr_req_word0 <= 8'hA5;
    @(posedge ref_clk);
    pwr_req <= 0;
    #1;
    chk("stream busy", power_stream_busy, 2'h1);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge pwr_ser_clk[0]);
      got[i] = pwr_ser_data[0];
    end
    chk("stream bits", got, 8'hA5);
    @(posedge pwr_ser_latch[0]);
    #1;
    chk("delay flags", {power_up_delay_busy[0], power_down_delay_busy[0]}, up ? 2'h2 : 2'h1);
    rchk(0, up ? 32'h00001C00 : 32'h00001A00);
    repeat (25) @(posedge ref_clk);
    #1;
    chk("flags clear", {power_stream_busy, power_up_delay_busy, power_down_delay_busy}, 0);
  endtask

  task automatic wrap_up();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    t_reset();
    t_write();
    t_activity();
    t_probe();
    t_power(1);
    t_power(0);
    wrap_up();
  end
endmodule
